// >>> core/lsd_defines.svh
/*
  Constants for the segment driver: chain lengths, level codes and timing.
  Assumes inclusion by bare name from files under core/ and testbench/.
*/
`ifndef LSD_DEFINES_SVH
`define LSD_DEFINES_SVH

// ==========================================
// Chain geometry
`define LSD_HALF_BITS 20
`define LSD_SEG_COUNT 40

// ==========================================
// Level select codes, top supply down to lowest bias
`define LSD_LVL_TOP 2'h0
`define LSD_LVL_SECOND 2'h1
`define LSD_LVL_THIRD 2'h2
`define LSD_LVL_LOWEST 2'h3

// ==========================================
// Reset values
`define LSD_CHAIN_RST 40'h0
`define LSD_LATCH_RST 40'h0

// ==========================================
// Timing: core clock period and shift clock limits
`define LSD_CORE_PERIOD_NS 25
`define LSD_SHIFT_PULSE_MIN_NS 125
`define LSD_SHIFT_PULSE_MIN_CYC ((`LSD_SHIFT_PULSE_MIN_NS + `LSD_CORE_PERIOD_NS - 1) / `LSD_CORE_PERIOD_NS)

`endif

// >>> core/lsd_pkg.sv
/*
  Types for the segment driver.
  Assumes lsd_defines.svh sits beside it in core/.
*/
`include "lsd_defines.svh"

package lsd_pkg;
  typedef logic [1:0] lsd_level_type;

  // Serial, shift clock, load and alternation inputs from the controller
  typedef struct packed {
    logic serial_in_low_half;
    logic serial_in_high_half;
    logic shift_clock;
    logic load;
    logic frame_alternation;
  } lsd_ctrl_type;

  // Cascade outputs
  typedef struct packed {
    logic chain_out_mid;
    logic chain_out_end;
  } lsd_chain_type;
endpackage

// >>> core/lsd_segment_driver.sv
/*
  Segment driver core: two 20-bit shift halves, a 40-bit load latch and
  per-segment level selection into 2-bit codes.
  Assumes controller inputs are synchronous to core_clk, and shift_clock
  is sampled, its falling edge detected on core_clk.
*/
// How it works
// [R1] Both halves shift on shift clock fall
// [R2] Controller presents one bit per falling edge
// [R3] Low input feeds 1..20; mid shows 20
// [R4] High input feeds 21..40; cascade makes 40
// [R5] End output presents position 40
// [R6] Load high passes chain into latch
// [R7] Load low holds latch despite shifting
// [R8] Each segment follows latch bit and alternation
// [R9] Truth table maps bit, alternation to level
// [R10] Controller drives alternation for polarity reversal
// [R11] Segment output is 2-bit level code
`timescale 1ns/1ps
`include "lsd_defines.svh"

module lsd_segment_driver #(
  parameter int HALF_BITS = `LSD_HALF_BITS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire lsd_pkg::lsd_ctrl_type ctrl,
  output lsd_pkg::lsd_chain_type chain,
  output lsd_pkg::lsd_level_type segment_outputs [2*HALF_BITS]
);
  import lsd_pkg::*;

  localparam int SEGS = 2 * HALF_BITS;

  // Each half needs at least two bits for the shift slices below
  if (HALF_BITS < 2) begin : gen_bad_half
    $error("HALF_BITS must be at least 2");
  end

  // ==========================================
  // Shift clock edge detect
  // Resets to the idle high level, so a pin held low at release counts as a fall
  logic shift_prev;
  logic shift_fall;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_prev <= 1'b1;
    end else begin
      shift_prev <= ctrl.shift_clock;
    end
  end

  assign shift_fall = shift_prev && !ctrl.shift_clock;

  // ==========================================
  // Shift chain; index 0 is position 1
  logic [SEGS-1:0] chain_bits;

  // [R1] Shift on fall
  // [R3] Low half input
  // [R4] High half input
  always_ff @(posedge core_clk) begin
    if (rst) begin
      chain_bits <= SEGS'(`LSD_CHAIN_RST);
    end else if (shift_fall) begin
      chain_bits[HALF_BITS-1:0] <= {chain_bits[HALF_BITS-2:0], ctrl.serial_in_low_half};
      chain_bits[SEGS-1:HALF_BITS] <= {chain_bits[SEGS-2:HALF_BITS], ctrl.serial_in_high_half};
    end
  end

  // [R3] Mid tap
  // [R5] End tap
  always_ff @(posedge core_clk) begin
    if (rst) begin
      chain <= '0;
    end else begin
      chain.chain_out_mid <= chain_bits[HALF_BITS-1];
      chain.chain_out_end <= chain_bits[SEGS-1];
    end
  end

  // ==========================================
  // Output latch; transparent while load is high
  logic [SEGS-1:0] latch_bits;
  logic [SEGS-1:0] live_bits;

  // Latch follows the chain with its shift applied, so a fall during load lands too
  always_comb begin
    live_bits = chain_bits;
    if (shift_fall) begin
      live_bits[HALF_BITS-1:0] = {chain_bits[HALF_BITS-2:0], ctrl.serial_in_low_half};
      live_bits[SEGS-1:HALF_BITS] = {chain_bits[SEGS-2:HALF_BITS], ctrl.serial_in_high_half};
    end
  end

  // [R6] Load passes chain
  // [R7] Hold when low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      latch_bits <= SEGS'(`LSD_LATCH_RST);
    end else if (ctrl.load) begin
      latch_bits <= live_bits;
    end
  end

  // ==========================================
  // Level selection per segment
  // Alternation is registered so it pairs with the latch value of the same edge
  logic alt_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      alt_q <= 1'b0;
    end else begin
      alt_q <= ctrl.frame_alternation;
    end
  end

  genvar g;
  generate
    for (g = 0; g < SEGS; g++) begin : gen_seg
      // [R8] Per segment select
      // [R9] Truth table
      // [R11] Two-bit level code
      always_ff @(posedge core_clk) begin
        if (rst) begin
          segment_outputs[g] <= `LSD_LVL_SECOND;
        end else begin
          unique case ({latch_bits[g], alt_q})
            2'b11: segment_outputs[g] <= `LSD_LVL_LOWEST;
            2'b10: segment_outputs[g] <= `LSD_LVL_TOP;
            2'b01: segment_outputs[g] <= `LSD_LVL_THIRD;
            2'b00: segment_outputs[g] <= `LSD_LVL_SECOND;
          endcase
        end
      end
    end
  endgenerate

  // ==========================================
  // Checks
  logic rst_q;

  always_ff @(posedge core_clk) begin
    rst_q <= rst;
  end

  // Expected level for one bit, written from the level table rather than the case above
  function automatic lsd_level_type level_of(input logic bit_v, input logic alt_v);
    if (bit_v) begin
      return alt_v ? `LSD_LVL_LOWEST : `LSD_LVL_TOP;
    end
    return alt_v ? `LSD_LVL_THIRD : `LSD_LVL_SECOND;
  endfunction

  // [R11] Reset code
  reset_state_a: assert property (@(posedge core_clk) // [R11]
    rst |=> chain_bits == '0 && latch_bits == '0 && segment_outputs[0] == `LSD_LVL_SECOND)
    else $error("reset did not clear chain, latch and segments");

  // [R1] Shift on fall
  shift_step_a: assert property (@(posedge core_clk) disable iff (rst) // [R1]
    shift_fall |=> chain_bits[0] == $past(ctrl.serial_in_low_half)
      && chain_bits[HALF_BITS] == $past(ctrl.serial_in_high_half))
    else $error("chain did not take serial bits on shift fall");

  // [R1] Still without fall
  shift_idle_a: assert property (@(posedge core_clk) disable iff (rst) // [R1]
    !shift_fall |=> $stable(chain_bits))
    else $error("chain moved without shift fall");

  // [R4] Halves step apart
  half_step_a: assert property (@(posedge core_clk) disable iff (rst) // [R4]
    shift_fall |=> chain_bits[HALF_BITS-1:1] == $past(chain_bits[HALF_BITS-2:0])
      && chain_bits[SEGS-1:HALF_BITS+1] == $past(chain_bits[SEGS-2:HALF_BITS]))
    else $error("a chain half did not step by one position");

  // [R3] Mid tap
  mid_tap_a: assert property (@(posedge core_clk) disable iff (rst || rst_q) // [R3]
    chain.chain_out_mid == $past(chain_bits[HALF_BITS-1]))
    else $error("mid output is not position 20");

  // [R5] End tap
  end_tap_a: assert property (@(posedge core_clk) disable iff (rst || rst_q) // [R5]
    chain.chain_out_end == $past(chain_bits[SEGS-1]))
    else $error("end output is not position 40");

  // [R6] Load passes
  load_pass_a: assert property (@(posedge core_clk) disable iff (rst) // [R6]
    ctrl.load |=> latch_bits == chain_bits)
    else $error("latch did not follow chain under load");

  // [R7] Hold on low
  latch_hold_a: assert property (@(posedge core_clk) disable iff (rst) // [R7]
    !ctrl.load |=> $stable(latch_bits))
    else $error("latch changed while load low");

  // [R7] Segments hold
  // Load low, then no alternation change: nothing feeding the segments can move
  sequence hold_inputs_s;
    !ctrl.load ##1 $stable(alt_q);
  endsequence
  seg_hold_a: assert property (@(posedge core_clk) disable iff (rst) // [R7]
    hold_inputs_s |=> $stable(segment_outputs[0]) && $stable(segment_outputs[SEGS-1]))
    else $error("segment output moved while latch held");

  // [R9] Level mapping
  level_map_a: assert property (@(posedge core_clk) disable iff (rst) // [R9]
    1'b1 |=> segment_outputs[0] == level_of($past(latch_bits[0]), $past(alt_q)))
    else $error("segment 0 level code wrong");

  // [R8] Last segment
  last_seg_a: assert property (@(posedge core_clk) disable iff (rst || rst_q) // [R8]
    $past(latch_bits[SEGS-1]) && !$past(alt_q) |-> segment_outputs[SEGS-1] == `LSD_LVL_TOP)
    else $error("last segment not at top level");

  // [R8] Load reaches segment
  // A load edge, one edge for the latch, then the segment shows the loaded bit
  sequence load_settle_s;
    ctrl.load ##1 1'b1;
  endsequence
  load_seg_a: assert property (@(posedge core_clk) disable iff (rst) // [R8]
    load_settle_s |=> segment_outputs[SEGS-1] == level_of($past(chain_bits[SEGS-1]), $past(alt_q)))
    else $error("loaded bit did not reach last segment");

endmodule

// >>> testbench/lsd_ctrl_model.sv
/*
  Controller model that shifts words into the segment driver.
  Assumes one bench process calls its tasks.
*/
`timescale 1ns/1ps
`include "lsd_defines.svh"
module lsd_ctrl_model (
  input wire logic core_clk,
  input wire logic chain_mid,
  input wire logic cascade,
  output lsd_pkg::lsd_ctrl_type ctrl
);
  import lsd_pkg::*;
  logic din = 1'b0;
  logic sclk = 1'b1;
  logic ld = 1'b0;
  logic alt = 1'b0;
  // cascade ties high input to mid
  assign ctrl = '{din, cascade ? chain_mid : ~din, sclk, ld, alt};
  // ==========
  // one bit per fall
  task automatic shift_word(input logic [39:0] w);
    for (int i = 39; i >= 0; i--) begin
      @(posedge core_clk) #1 din = w[i];
      repeat (`LSD_SHIFT_PULSE_MIN_CYC) @(posedge core_clk);
      #1 sclk = 1'b0;
      repeat (`LSD_SHIFT_PULSE_MIN_CYC) @(posedge core_clk);
      #1 sclk = 1'b1;
      // Stale data is inverted so it cannot pass as held
      din = ~w[i];
    end
  endtask
  task automatic pulse_load(input logic a);
    repeat (10) @(posedge core_clk);
    #1 ld = 1'b1;
    alt = a;
    repeat (5) @(posedge core_clk);
    #1 ld = 1'b0;
  endtask
  task automatic set_alt(input logic a);
    @(posedge core_clk) #1 alt = a;
  endtask
  // Load level held by the caller across shifts
  task automatic set_load(input logic l);
    @(posedge core_clk) #1 ld = l;
  endtask
endmodule

// >>> testbench/lsd_segment_driver_tb.sv
/*
  Self-checking bench for the segment driver.
  Assumes the controller model drives ctrl; the bench drives clock and reset.
*/
`timescale 1ns/1ps
`include "lsd_defines.svh"
module lsd_segment_driver_tb;
  import lsd_pkg::*;
  typedef struct packed {logic casc; logic [39:0] word; logic alt;} lsd_row_type;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cascade = 1'b1;
  logic [39:0] exp;
  lsd_ctrl_type ctrl;
  lsd_chain_type chain;
  lsd_level_type seg [40];
  int miscompares = 0;
  int n_compared = 0;
  lsd_row_type rows [4] = '{'{1'b1, 40'hA5C30F961E, 1'b0}, '{1'b1, 40'h8000000001, 1'b1},
    '{1'b0, 40'h3C9A5FE071, 1'b1}, '{1'b0, 40'hFF0F00F0AA, 1'b0}};
  lsd_segment_driver i_lsd_segment_driver (.core_clk(core_clk), .rst(rst), .ctrl(ctrl), .chain(chain),
    .segment_outputs(seg));
  lsd_ctrl_model i_lsd_ctrl_model (.core_clk(core_clk), .chain_mid(chain.chain_out_mid), .cascade(cascade),
    .ctrl(ctrl));
  // ==========
  // bit and alternation pick the level
  function automatic lsd_level_type lvl(input logic b, input logic a);
    return b ? (a ? `LSD_LVL_LOWEST : `LSD_LVL_TOP) : (a ? `LSD_LVL_THIRD : `LSD_LVL_SECOND);
  endfunction
  task automatic chk_bit(input logic got, input logic want);
    n_compared++;
    if (got !== want) begin
      miscompares++;
      $display("MISMATCH %0t chain output", $time);
    end
  endtask
  task automatic chk_segs(input logic [39:0] w, input logic a);
    for (int i = 0; i < 40; i++) begin
      n_compared++;
      if (seg[i] !== lvl(w[i], a)) begin
        miscompares++;
        $display("MISMATCH %0t segment %0d", $time, i);
      end
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========
  initial forever #12.5 core_clk = ~core_clk;
  initial begin
    #1ms;
    miscompares++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    chk_segs(40'h0, 1'b0);
    chk_bit(chain.chain_out_end, 1'b0);
    foreach (rows[r]) begin
      // Split halves: high input carries the inverse of low
      exp = rows[r].casc ? rows[r].word : {~rows[r].word[19:0], rows[r].word[19:0]};
      cascade = rows[r].casc;
      i_lsd_ctrl_model.shift_word(rows[r].word);
      chk_bit(chain.chain_out_mid, exp[19]);
      chk_bit(chain.chain_out_end, exp[39]);
      i_lsd_ctrl_model.pulse_load(rows[r].alt);
      repeat (2) @(posedge core_clk);
      #1 chk_segs(exp, rows[r].alt);
    end
    i_lsd_ctrl_model.shift_word(~rows[3].word);
    chk_segs(exp, rows[3].alt);
    i_lsd_ctrl_model.set_alt(~rows[3].alt);
    repeat (2) @(posedge core_clk);
    #1 chk_segs(exp, ~rows[3].alt);
    // Shift with load held high: the latch tracks every step
    exp = {~rows[2].word[19:0], rows[2].word[19:0]};
    i_lsd_ctrl_model.set_load(1'b1);
    i_lsd_ctrl_model.shift_word(rows[2].word);
    repeat (2) @(posedge core_clk);
    #1 chk_segs(exp, ~rows[3].alt);
    i_lsd_ctrl_model.set_load(1'b0);
    @(posedge core_clk) #1 rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    chk_segs(40'h0, 1'b0);
    chk_bit(chain.chain_out_mid, 1'b0);
    chk_bit(chain.chain_out_end, 1'b0);
    // Alternation is still high, so cleared bits settle at the third level
    repeat (2) @(posedge core_clk);
    #1 chk_segs(40'h0, ~rows[3].alt);
    final_report;
  end
endmodule
